// *** rtl/mie_core.sv ***
/*
 * Instruction sequencer and data path of a small 8-bit core: fetch, decode,
 * execute, program counter, return stack and flags.
 * Assumes a program memory that returns data one clock after pm_rd and a
 * data memory that answers reads combinationally and writes on dm_we.
 */
`timescale 1ns/1ps
`include "mie_params.svh"
module mie_core #(
  parameter int STACK_DEPTH = 16
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        resetn,
  // Program memory
  output logic [11:0]      pm_addr,
  output logic             pm_rd,
  input  wire logic [15:0] pm_data,
  // Data memory
  output logic [7:0]       dm_addr,
  input  wire logic [7:0]  dm_rdata,
  output logic             dm_we,
  output logic [7:0]       dm_wdata,
  // Status
  output logic [7:0]       working_register,
  output logic [3:0]       status_flags,
  output logic [7:0]       table_high,
  output logic             halted,
  output logic             wdt_clear
);
  import mie_pkg::*;

  localparam int SP_W = $clog2(STACK_DEPTH);

  // ****************************************************************
  // State
  // ****************************************************************
  mie_state_e  st_r;
  mie_state_e  st_nxt_r;
  logic [1:0]  ph_r;
  logic [11:0] pc_r;
  logic [11:0] pm_addr_r;
  logic [15:0] ir_r;
  logic [15:0] tbl_r;
  logic [7:0]  wreg_r;
  logic [7:0]  tblh_r;
  logic        z_r;
  logic        c_r;
  logic        hc_r;
  logic        wrap_r;
  logic        dm_we_r;
  logic [7:0]  dm_wdata_r;
  logic        wdt_r;
  logic [11:0] stk_r [STACK_DEPTH];
  logic [SP_W-1:0] sp_r;

  mie_alu_if alu_bus ();
  mie_alu u_alu (.bus(alu_bus));

  // ****************************************************************
  // Decode
  // ****************************************************************
  mie_class_e  cls;
  mie_misc_e   misc;
  mie_skip_e   skop;
  logic [7:0]  arg;
  logic [2:0]  bit_i;
  logic [7:0]  bit_mask;
  logic [7:0]  operand;
  logic [7:0]  bit_res;
  logic [7:0]  m_data;
  logic [7:0]  res;
  logic        alu_cls;
  logic        is_arith;
  logic        is_logic;
  logic        is_rotc;
  logic        is_exit;
  logic        is_tab;
  logic        is_halt;
  logic        is_wdt;
  logic        skip_take;
  logic        write_m;
  logic        write_a;
  logic        pc_low_wr;
  logic        need_extra;
  logic        commit;
  logic        x_commit;
  logic [SP_W-1:0] sp_pop;
  logic [11:0] stk_top;
  logic [11:0] pc_seq;
  logic [11:0] pc_nxt;
  logic [11:0] tab_addr;

  assign cls      = mie_class_e'(ir_r[`MIE_CLASS_MSB:`MIE_CLASS_LSB]);
  assign misc     = mie_misc_e'(ir_r[`MIE_OP_MSB:`MIE_OP_LSB]);
  assign skop     = mie_skip_e'(ir_r[`MIE_OP_MSB:`MIE_OP_LSB]);
  assign arg      = ir_r[`MIE_ARG_MSB:0];
  assign bit_i    = ir_r[`MIE_BIT_MSB:`MIE_BIT_LSB];
  assign bit_mask = 8'h01 << bit_i;
  // A read of the low program counter byte sees the live counter.
  assign operand  = (arg == `MIE_PC_LOW_ADDR) ? pc_r[7:0] : dm_rdata;
  assign res      = alu_bus.res;

  assign alu_cls  = (cls == CL_ALU_A) || (cls == CL_ALU_M) || (cls == CL_ALU_I);
  assign is_arith = alu_cls && (alu_bus.op <= OP_SBC);
  assign is_logic = alu_cls && (alu_bus.op >= OP_AND) && (alu_bus.op <= OP_DECR);
  assign is_rotc  = alu_cls && ((alu_bus.op == OP_RORC) || (alu_bus.op == OP_ROLC));
  assign is_exit  = (cls == CL_MISC) && ((misc == MS_SUBX) || (misc == MS_INTX));
  assign is_tab   = (cls == CL_MISC) && (misc == MS_TABRD);
  assign is_halt  = (cls == CL_MISC) && (misc == MS_HALT);
  assign is_wdt   = (cls == CL_MISC) && (misc == MS_WDT);

  // Skip instructions share the unit: increment, decrement or pass through.
  assign alu_bus.op   = alu_cls ? mie_op_e'(ir_r[`MIE_OP_MSB:`MIE_OP_LSB]) :
                        ((skop == SB_SIZ) || (skop == SB_SIZA)) ? OP_INC :
                        ((skop == SB_SDZ) || (skop == SB_SDZA)) ? OP_DECR : OP_PASS;
  assign alu_bus.a    = wreg_r;
  assign alu_bus.b    = (cls == CL_ALU_I) ? arg : operand;
  assign alu_bus.c_in = c_r;

  assign bit_res  = (cls == CL_BSET) ? (operand | bit_mask) : (operand & ~bit_mask);
  assign skip_take = ((cls == CL_SKB0) && !operand[bit_i]) ||
                     ((cls == CL_SKB1) && operand[bit_i]) ||
                     ((cls == CL_SKBYTE) && (res == 8'h00));
  assign write_m  = (cls == CL_ALU_M) || (cls == CL_BSET) || (cls == CL_BCLR) ||
                    (cls == CL_STORE) ||
                    ((cls == CL_SKBYTE) && ((skop == SB_SIZ) || (skop == SB_SDZ)));
  assign write_a  = (cls == CL_ALU_A) || (cls == CL_ALU_I) ||
                    ((cls == CL_SKBYTE) && ((skop == SB_SZA) || (skop == SB_SIZA) ||
                                            (skop == SB_SDZA)));
  assign m_data   = (cls == CL_STORE) ? wreg_r :
                    ((cls == CL_BSET) || (cls == CL_BCLR)) ? bit_res : res;
  assign pc_low_wr = write_m && (arg == `MIE_PC_LOW_ADDR);
  assign need_extra = (cls == CL_JUMP) || (cls == CL_CALL) || is_exit || is_tab ||
                      pc_low_wr || skip_take;

  // ****************************************************************
  // Program counter and stack
  // ****************************************************************
  assign sp_pop   = sp_r - SP_W'(1);
  assign stk_top  = stk_r[sp_pop];
  assign pc_seq   = pc_r + 12'h001;
  assign tab_addr = {pc_r[11:8], wreg_r};
  assign pc_nxt   = ((cls == CL_JUMP) || (cls == CL_CALL)) ? ir_r[`MIE_TARGET_MSB:0] :
                    is_exit   ? stk_top :
                    pc_low_wr ? {pc_r[11:8], m_data} :
                    skip_take ? pc_r + 12'h002 : pc_seq;

  // Execution happens in the third clock of each four-clock instruction cycle.
  assign commit   = (st_r == ST_RUN) && (ph_r == `MIE_COMMIT_PH);
  assign x_commit = (st_r == ST_EXTRA) && (ph_r == `MIE_COMMIT_PH);

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign pm_addr  = pm_addr_r;
  assign pm_rd    = (ph_r == `MIE_FETCH_PH) &&
                    ((st_r == ST_RUN) || ((st_r == ST_EXTRA) && is_tab));
  assign dm_addr  = arg;
  assign dm_we    = dm_we_r;
  assign dm_wdata = dm_wdata_r;
  assign working_register = wreg_r;
  assign status_flags     = {wrap_r, hc_r, c_r, z_r};
  assign table_high       = tblh_r;
  assign halted           = (st_r == ST_HALT);
  assign wdt_clear        = wdt_r;

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (!resetn) begin
      ph_r      <= `MIE_FETCH_PH;
      st_r      <= ST_RUN;
      st_nxt_r  <= ST_RUN;
      pc_r      <= `MIE_PC_RESET;
      pm_addr_r <= `MIE_PC_RESET;
      ir_r      <= 16'h0000;
      tbl_r     <= 16'h0000;
      sp_r      <= '0;
    end else begin
      ph_r <= ph_r + 2'h1;
      if (ph_r == `MIE_LAST_PH) begin
        st_r <= st_nxt_r;
      end
      if ((ph_r == `MIE_LATCH_PH) && (st_r == ST_RUN)) begin
        ir_r <= pm_data;
      end
      if ((ph_r == `MIE_LATCH_PH) && (st_r == ST_EXTRA)) begin
        tbl_r <= pm_data;
      end
      if (commit) begin
        st_nxt_r  <= is_halt ? ST_HALT : (need_extra ? ST_EXTRA : ST_RUN);
        pc_r      <= pc_nxt;
        pm_addr_r <= is_tab ? tab_addr : pc_nxt;
        if (cls == CL_CALL) begin
          sp_r <= sp_r + SP_W'(1);
        end else if (is_exit) begin
          sp_r <= sp_pop;
        end
      end
      if (x_commit) begin
        st_nxt_r  <= ST_RUN;
        pm_addr_r <= pc_r;
      end
    end
  end

  // The return stack has no reset; a call past the last level wraps.
  always_ff @(posedge clock) begin
    if (commit && (cls == CL_CALL)) begin
      stk_r[sp_r] <= pc_seq;
    end
  end

  // ****************************************************************
  // Data path
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (!resetn) begin
      wreg_r     <= `MIE_WREG_RESET;
      tblh_r     <= 8'h00;
      {wrap_r, hc_r, c_r, z_r} <= 4'h0;
      dm_we_r    <= 1'b0;
      dm_wdata_r <= 8'h00;
      wdt_r      <= 1'b0;
    end else begin
      dm_we_r <= (commit && write_m) || (x_commit && is_tab);
      wdt_r   <= commit && is_wdt;
      if (commit && write_m) begin
        dm_wdata_r <= m_data;
      end
      if (x_commit && is_tab) begin
        dm_wdata_r <= tbl_r[7:0];
        tblh_r     <= tbl_r[15:8];
      end
      if (commit && write_a) begin
        wreg_r <= res;
      end
      if (commit && (is_arith || is_logic)) begin
        z_r <= (res == 8'h00);
      end
      if (commit && (is_arith || is_rotc)) begin
        c_r <= alu_bus.c_out;
      end
      if (commit && is_arith) begin
        hc_r <= alu_bus.hc;
        wrap_r <= alu_bus.wrap;
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_FETCH_SPACING: assert property (@(posedge clock) disable iff (!resetn)
    pm_rd |=> !pm_rd [*3]) else $error("fetch strobes closer than four clocks");

  AST_RESET_FETCH: assert property (@(posedge clock) disable iff (!resetn)
    $rose(resetn) |-> (pm_rd && (pm_addr == 12'h000)))
    else $error("first fetch after reset not at address zero");

  AST_EXTRA_CYCLE: assert property (@(posedge clock) disable iff (!resetn)
    (commit && need_extra && !is_halt) |-> ##2 (st_r == ST_EXTRA) [*4] ##1 (st_r == ST_RUN))
    else $error("branching instruction did not take exactly one extra cycle");

  AST_SINGLE_CYCLE: assert property (@(posedge clock) disable iff (!resetn)
    (commit && !need_extra && !is_halt) |-> ##2 (pm_rd && (st_r == ST_RUN)))
    else $error("plain instruction did not retire in one cycle");

  AST_SKIP_TARGET: assert property (@(posedge clock) disable iff (!resetn)
    (commit && skip_take) |=> (pc_r == $past(pc_r) + 12'h002))
    else $error("taken skip did not bypass one instruction");

  AST_RETURN_POINT: assert property (@(posedge clock) disable iff (!resetn)
    (commit && (cls == CL_CALL)) |=> (stk_r[$past(sp_r)] == $past(pc_r) + 12'h001))
    else $error("call saved a wrong return point");

  AST_RETURN_PC: assert property (@(posedge clock) disable iff (!resetn)
    (commit && is_exit) |=> (pc_r == $past(stk_top)))
    else $error("return did not resume at saved point");

  AST_BIT_ONLY: assert property (@(posedge clock) disable iff (!resetn)
    (commit && ((cls == CL_BSET) || (cls == CL_BCLR))) |=>
      (dm_we && ((dm_wdata & ~$past(bit_mask)) == ($past(operand) & ~$past(bit_mask))) &&
       ((dm_wdata & $past(bit_mask)) == ((cls == CL_BSET) ? $past(bit_mask) : 8'h00))))
    else $error("bit operation changed other bits");

  AST_PC_LOW_REDIRECT: assert property (@(posedge clock) disable iff (!resetn)
    (commit && pc_low_wr) |=> ((pc_r[7:0] == dm_wdata) && (st_nxt_r == ST_EXTRA)))
    else $error("program counter low write did not redirect");

  AST_LOGIC_ZERO: assert property (@(posedge clock) disable iff (!resetn)
    (commit && is_logic) |=> (z_r == ($past(res) == 8'h00)))
    else $error("zero flag wrong after logic operation");

  AST_INC_ONE: assert property (@(posedge clock) disable iff (!resetn)
    (commit && alu_cls && (alu_bus.op == OP_INC)) |=>
      (((cls == CL_ALU_M) ? dm_wdata : wreg_r) == $past(alu_bus.b) + 8'h01))
    else $error("increment did not add exactly one");

  AST_JUMP_NO_PUSH: assert property (@(posedge clock) disable iff (!resetn)
    (commit && (cls == CL_JUMP)) |=> ($stable(sp_r) && (pc_r == $past(ir_r[11:0]))))
    else $error("branch moved the stack or missed its target");
endmodule // mie_core

// *** rtl/mie_params.svh ***
/*
 * Constants of the instruction execution core: timing counts, field positions,
 * fixed data memory offsets and reset values.
 * Assumes inclusion by mie_core only; it holds definitions only.
 */
`ifndef MIE_PARAMS_SVH
`define MIE_PARAMS_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define MIE_CLK_PERIOD_NS   100
`define MIE_REF_OSC_KHZ     8000
`define MIE_REF_INSTR_NS    500
`define MIE_SYS_PER_INSTR   ((`MIE_REF_INSTR_NS * `MIE_REF_OSC_KHZ) / 1000000)
`define MIE_FETCH_PH        2'h0
`define MIE_LATCH_PH        2'h1
`define MIE_COMMIT_PH       2'h2
`define MIE_LAST_PH         2'h3

// ****************************************************************
// Instruction word fields
// ****************************************************************
`define MIE_CLASS_MSB       15
`define MIE_CLASS_LSB       12
`define MIE_OP_MSB          11
`define MIE_OP_LSB          8
`define MIE_BIT_MSB         10
`define MIE_BIT_LSB         8
`define MIE_ARG_MSB         7
`define MIE_TARGET_MSB      11

// ****************************************************************
// Data memory map and reset values
// ****************************************************************
`define MIE_PC_LOW_ADDR     8'h06
`define MIE_PC_RESET        12'h000
`define MIE_WREG_RESET      8'h00
`endif

// *** rtl/mie_pkg.sv ***
/*
 * Types of the instruction execution core: instruction classes, operations
 * and sequencer states.
 * Assumes that the encodings are this core's own and no assembler is shared.
 */
package mie_pkg;
  typedef enum logic [3:0] {
    CL_MISC, CL_ALU_A, CL_ALU_M, CL_ALU_I, CL_BSET, CL_BCLR, CL_SKB0, CL_SKB1,
    CL_SKBYTE, CL_STORE, CL_JUMP, CL_CALL
  } mie_class_e;
  typedef enum logic [3:0] {
    OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_AND, OP_OR, OP_XOR, OP_CPL,
    OP_INC, OP_DECR, OP_ROR, OP_ROL, OP_RORC, OP_ROLC, OP_PASS
  } mie_op_e;
  typedef enum logic [3:0] {
    MS_NOP, MS_HALT, MS_WDT, MS_SUBX, MS_INTX, MS_TABRD
  } mie_misc_e;
  typedef enum logic [3:0] {
    SB_SZ, SB_SZA, SB_SIZ, SB_SDZ, SB_SIZA, SB_SDZA
  } mie_skip_e;
  typedef enum logic [1:0] {ST_RUN, ST_EXTRA, ST_HALT} mie_state_e;
endpackage

// *** rtl/mie_alu_if.sv ***
/*
 * Carrier between the sequencer and the arithmetic unit.
 * Assumes a purely combinational unit on the far side.
 */
`timescale 1ns/1ps
interface mie_alu_if;
  import mie_pkg::*;
  mie_op_e    op;
  logic [7:0] a;
  logic [7:0] b;
  logic       c_in;
  logic [7:0] res;
  logic       c_out;
  logic       hc;
  logic       wrap;
  modport core (output op, a, b, c_in, input res, c_out, hc, wrap);
  modport alu  (input op, a, b, c_in, output res, c_out, hc, wrap);
endinterface

// *** rtl/mie_alu.sv ***
/*
 * Combinational 8-bit arithmetic and logic unit.
 * Assumes the caller decides which flags an operation updates.
 */
`timescale 1ns/1ps
module mie_alu (
  mie_alu_if.alu bus
);
  import mie_pkg::*;

  logic       is_sub;
  logic [7:0] b2;
  logic       cin;
  logic [8:0] sum;
  logic [4:0] hsum;

  // Subtraction adds the complement, so carry set means no borrow.
  assign is_sub = (bus.op == OP_SUB) || (bus.op == OP_SBC);
  assign b2     = is_sub ? ~bus.b : bus.b;
  assign cin    = (bus.op == OP_ADD) ? 1'b0 : ((bus.op == OP_SUB) ? 1'b1 : bus.c_in);
  assign sum    = {1'b0, bus.a} + {1'b0, b2} + {8'h00, cin};
  assign hsum   = {1'b0, bus.a[3:0]} + {1'b0, b2[3:0]} + {4'h0, cin};
  assign bus.hc = hsum[4];
  assign bus.wrap = (bus.a[7] == b2[7]) && (sum[7] != bus.a[7]);

  always_comb begin
    bus.c_out = bus.c_in;
    unique case (bus.op)
      OP_ADD, OP_ADC, OP_SUB, OP_SBC: begin
        bus.res   = sum[7:0];
        bus.c_out = sum[8];
      end
      OP_AND:  bus.res = bus.a & bus.b;
      OP_OR:   bus.res = bus.a | bus.b;
      OP_XOR:  bus.res = bus.a ^ bus.b;
      OP_CPL:  bus.res = ~bus.b;
      OP_INC:  bus.res = bus.b + 8'h01;
      OP_DECR: bus.res = bus.b - 8'h01;
      OP_ROR:  bus.res = {bus.b[0], bus.b[7:1]};
      OP_ROL:  bus.res = {bus.b[6:0], bus.b[7]};
      OP_RORC: begin
        bus.res   = {bus.c_in, bus.b[7:1]};
        bus.c_out = bus.b[0];
      end
      OP_ROLC: begin
        bus.res   = {bus.b[6:0], bus.c_in};
        bus.c_out = bus.b[7];
      end
      OP_PASS: bus.res = bus.b;
      default: bus.res = bus.b;
    endcase
  end
endmodule // mie_alu

// *** tb/mie_core_tb_top.sv ***
/*
 * Self-checking bench for the instruction execution core: one-instruction programs from a
 * table, then calls and returns, table read, a jump loop and a reset in mid-run.
 * Assumes mie_pkg and mie_params.svh are compiled with the design files.
 */
`timescale 1ns/1ps
module mie_core_tb_top;
  import mie_pkg::*;

  // ****************************************************************
  // Types, signals and memory models
  // ****************************************************************
  typedef struct {
    logic [7:0]  a0;
    logic [7:0]  m0;
    logic [15:0] ins;
    logic [7:0]  ea;
    logic [7:0]  em;
    logic [3:0]  fm;
    logic [3:0]  fv;
    int          cyc;
    logic [11:0] nxt;
  } mie_row_s;

  logic        clock;
  logic        resetn;
  logic [11:0] pm_addr;
  logic        pm_rd;
  logic [15:0] pm_data;
  logic [7:0]  dm_addr;
  logic [7:0]  dm_rdata;
  logic        dm_we;
  logic [7:0]  dm_wdata;
  logic [7:0]  working_register;
  logic [3:0]  status_flags;
  logic [7:0]  table_high;
  logic        halted;
  logic        wdt_clear;
  logic [15:0] rom [0:4095];
  logic [7:0]  ram [0:255];
  logic [11:0] fa [0:15];
  int          ft [0:15];
  int          nf;
  int          now_c;
  int          wdt_n;
  int          tick;
  int          err_count;
  int          check_count;

  // Every row runs: fetch 0 loads the accumulator, fetch 1 is the instruction under test.
  mie_row_s rows [0:32] = '{
    '{8'h7F, 8'h01, 16'h1010, 8'h80, 8'h01, 4'hF, 4'hC, 1, 12'h002},
    '{8'hFF, 8'h01, 16'h1010, 8'h00, 8'h01, 4'hF, 4'h7, 1, 12'h002},
    '{8'h00, 8'h01, 16'h1210, 8'hFF, 8'h01, 4'h3, 4'h0, 1, 12'h002},
    '{8'h05, 8'h05, 16'h1210, 8'h00, 8'h05, 4'h3, 4'h3, 1, 12'h002},
    '{8'h10, 8'h20, 16'h2010, 8'h10, 8'h30, 4'hF, 4'h0, 1, 12'h002},
    '{8'h05, 8'h02, 16'h1310, 8'h02, 8'h02, 4'h3, 4'h2, 1, 12'h002},
    '{8'hF0, 8'h00, 16'h340F, 8'h00, 8'h00, 4'hF, 4'h1, 1, 12'h002},
    '{8'h01, 8'h02, 16'h1510, 8'h03, 8'h02, 4'hF, 4'h0, 1, 12'h002},
    '{8'h5A, 8'h5A, 16'h1610, 8'h00, 8'h5A, 4'hF, 4'h1, 1, 12'h002},
    '{8'h00, 8'hFF, 16'h1710, 8'h00, 8'hFF, 4'hF, 4'h1, 1, 12'h002},
    '{8'h00, 8'hFF, 16'h2810, 8'h00, 8'h00, 4'hF, 4'h1, 1, 12'h002},
    '{8'h00, 8'h00, 16'h1910, 8'hFF, 8'h00, 4'hF, 4'h0, 1, 12'h002},
    '{8'h00, 8'h01, 16'h1C10, 8'h00, 8'h01, 4'hF, 4'h2, 1, 12'h002},
    '{8'h00, 8'h80, 16'h2D10, 8'h00, 8'h00, 4'hF, 4'h2, 1, 12'h002},
    '{8'h00, 8'h01, 16'h1A10, 8'h80, 8'h01, 4'hF, 4'h0, 1, 12'h002},
    '{8'h00, 8'h80, 16'h1B10, 8'h01, 8'h80, 4'hF, 4'h0, 1, 12'h002},
    '{8'h00, 8'h3C, 16'h1E10, 8'h3C, 8'h3C, 4'hF, 4'h0, 1, 12'h002},
    '{8'h00, 8'h00, 16'h3EC3, 8'hC3, 8'h00, 4'hF, 4'h0, 1, 12'h002},
    '{8'hA5, 8'h00, 16'h9010, 8'hA5, 8'hA5, 4'hF, 4'h0, 1, 12'h002},
    '{8'h00, 8'h00, 16'h4310, 8'h00, 8'h08, 4'hF, 4'h0, 1, 12'h002},
    '{8'h00, 8'hFF, 16'h5710, 8'h00, 8'h7F, 4'hF, 4'h0, 1, 12'h002},
    '{8'h00, 8'h00, 16'h6010, 8'h00, 8'h00, 4'hF, 4'h0, 2, 12'h003},
    '{8'h00, 8'h01, 16'h6010, 8'h00, 8'h01, 4'hF, 4'h0, 1, 12'h002},
    '{8'h00, 8'h80, 16'h7710, 8'h00, 8'h80, 4'hF, 4'h0, 2, 12'h003},
    '{8'h00, 8'h00, 16'h8010, 8'h00, 8'h00, 4'hF, 4'h0, 2, 12'h003},
    '{8'h11, 8'h00, 16'h8110, 8'h00, 8'h00, 4'hF, 4'h0, 2, 12'h003},
    '{8'h00, 8'hFF, 16'h8210, 8'h00, 8'h00, 4'hF, 4'h0, 2, 12'h003},
    '{8'h00, 8'h02, 16'h8310, 8'h00, 8'h01, 4'hF, 4'h0, 1, 12'h002},
    '{8'h00, 8'h05, 16'h8410, 8'h06, 8'h05, 4'hF, 4'h0, 1, 12'h002},
    '{8'h00, 8'h01, 16'h8510, 8'h00, 8'h01, 4'hF, 4'h0, 2, 12'h003},
    '{8'h00, 8'h00, 16'hA005, 8'h00, 8'h00, 4'hF, 4'h0, 2, 12'h005},
    '{8'h05, 8'h00, 16'h9006, 8'h05, 8'h00, 4'hF, 4'h0, 2, 12'h005},
    '{8'h00, 8'h00, 16'h0200, 8'h00, 8'h00, 4'hF, 4'h0, 1, 12'h002}
  };

  mie_core #(.STACK_DEPTH(16)) dut (
    .clock            (clock),
    .resetn           (resetn),
    .pm_addr          (pm_addr),
    .pm_rd            (pm_rd),
    .pm_data          (pm_data),
    .dm_addr          (dm_addr),
    .dm_rdata         (dm_rdata),
    .dm_we            (dm_we),
    .dm_wdata         (dm_wdata),
    .working_register (working_register),
    .status_flags     (status_flags),
    .table_high       (table_high),
    .halted           (halted),
    .wdt_clear        (wdt_clear)
  );

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // Data memory answers combinationally; program memory answers one clock after the strobe.
  // Between fetches the program word toggles so a late sample cannot pass by luck.
  assign dm_rdata = ram[dm_addr];

  always @(posedge clock) begin
    if (dm_we === 1'b1) ram[dm_addr] <= dm_wdata;
    pm_data <= (pm_rd === 1'b1) ? rom[pm_addr] : ~pm_data;
    tick <= tick + 1;
    if (resetn !== 1'b1) begin
      nf <= 0;
      now_c <= 0;
      wdt_n <= 0;
    end else begin
      now_c <= now_c + 1;
      if (wdt_clear === 1'b1) wdt_n <= wdt_n + 1;
      if (pm_rd === 1'b1 && nf < 16) begin
        fa[nf] <= pm_addr;
        ft[nf] <= now_c;
        nf <= nf + 1;
      end
    end
    if (tick == 6000) begin
      err_count++;
      $display("unexpected at %0t ns: run did not finish in time", $time);
      results();
    end
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic check(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("unexpected at %0t ns: %s", $time, msg);
    end
  endtask

  task automatic load(input logic [7:0] a0, input logic [7:0] m0, input logic [15:0] ins);
    for (int i = 0; i < 4096; i++) rom[i] = 16'h0100;
    for (int i = 0; i < 256; i++) ram[i] = 8'h5A ^ i[7:0];
    rom[0] = {8'h3E, a0};
    rom[1] = ins;
    rom[12'h040] = 16'hBEEF;
    ram[8'h10] = m0;
  endtask

  // Resets the core, checks the reset state, then runs until halt or the cycle limit.
  task automatic run_prog(input int lim);
    int n;
    n = 0;
    @(posedge clock);
    resetn <= 1'b0;
    @(posedge clock);
    #1;
    check(pm_addr === 12'h000 && pm_rd === 1'b1 && dm_we === 1'b0, "reset bus state");
    check(working_register === 8'h00 && status_flags === 4'h0 && halted === 1'b0, "reset data");
    @(posedge clock);
    resetn <= 1'b1;
    while (halted !== 1'b1 && n < lim) begin
      @(posedge clock);
      n++;
    end
    repeat (8) @(posedge clock);
    #1;
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    resetn = 1'b0;
    pm_data = 16'h0000;
    err_count = 0;
    check_count = 0;
    tick = 0;
    foreach (rows[k]) begin
      load(rows[k].a0, rows[k].m0, rows[k].ins);
      run_prog(200);
      check(working_register === rows[k].ea, "accumulator value");
      check(ram[8'h10] === rows[k].em, "memory byte value");
      check((status_flags & rows[k].fm) === rows[k].fv, "flag value");
      check(fa[0] === 12'h000 && ft[0] == 0 && fa[1] === 12'h001, "fetch start");
      check(ft[1] - ft[0] == 4, "instruction cycle length");
      check(fa[2] === rows[k].nxt && ft[2] - ft[1] == 4 * rows[k].cyc, "next fetch");
      check(halted === 1'b1 && nf == 3, "halt stops fetching");
      check(wdt_n == ((rows[k].ins === 16'h0200) ? 1 : 0), "watchdog service");
      $display("row %0d done", k);
    end

    // Nested call and both returns.
    load(8'h00, 8'h00, 16'h0100);
    rom[0] = 16'hB020;
    rom[12'h020] = 16'h3E77;
    rom[12'h021] = 16'hB030;
    rom[12'h022] = 16'h0300;
    rom[12'h030] = 16'h0400;
    run_prog(200);
    check(fa[1] === 12'h020 && ft[1] == 8, "call target and time");
    check(fa[3] === 12'h030 && fa[4] === 12'h022 && ft[4] - ft[3] == 8, "inner return");
    check(fa[5] === 12'h001 && ft[5] - ft[4] == 8, "outer return");
    check(working_register === 8'h77, "subroutine result");
    $display("call test done");

    // Table read with the table address taken from the accumulator.
    load(8'h40, 8'h00, 16'h0510);
    run_prog(200);
    check(fa[2] === 12'h040 && fa[3] === 12'h002 && ft[3] - ft[1] == 8, "table timing");
    check(ram[8'h10] === 8'hEF && table_high === 8'hBE, "table data");
    $display("table test done");

    // Add with carry picks up the carry left by the add just before it.
    load(8'hFF, 8'h01, 16'h1010);
    rom[2] = 16'h1110;
    run_prog(200);
    check(working_register === 8'h02 && status_flags === 4'h0, "add with carry");
    $display("carry test done");

    // An endless jump loop, then a reset in mid-run must restart at address zero.
    load(8'h00, 8'h00, 16'hA000);
    run_prog(40);
    check(halted === 1'b0 && fa[2] === 12'h000 && ft[2] - ft[1] == 8, "jump loop");
    load(8'h00, 8'h00, 16'h0000);
    run_prog(200);
    check(fa[0] === 12'h000 && fa[1] === 12'h001 && halted === 1'b1, "restart");
    $display("reset test done");
    results();
  end
endmodule // mie_core_tb_top
